// *** rtl/npc_pkg.sv ***
// shared constants and types of the nand page/cache host controller
package npc_pkg;
    // clock and timing
    localparam int CLK_NS      = 100;
    localparam int TWB_NS      = 100;
    localparam int TWB_CYC     = (TWB_NS + CLK_NS - 1) / CLK_NS;
    localparam int END_NS      = 5000;
    localparam int END_CYC     = END_NS / CLK_NS;
    localparam int WAIT_W      = 16;

    // register map (byte addresses)
    localparam int ADR_W       = 8;
    localparam logic [7:0] REG_CMD  = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_CFG  = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;

    // field positions
    localparam int CMD_BYTE_LSB = 0;
    localparam int CMD_OP_LSB   = 8;
    localparam int CMD_LAST_BIT = 11;
    localparam int CFG_WP_BIT   = 0;
    localparam int CFG_POLL_BIT = 1;
    localparam int ST_ENG_BIT   = 0;
    localparam int ST_RDY_BIT   = 1;
    localparam int ST_REF_BIT   = 2;
    localparam int ST_TMO_BIT   = 3;
    localparam int ST_CRD_BIT   = 4;
    localparam int ST_PRG_BIT   = 5;
    localparam int ST_STM_BIT   = 6;
    localparam int ST_WAIT_BIT  = 7;
    localparam int ST_DATA_LSB  = 8;
    localparam int ST_PART_LSB  = 16;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // flash command bytes
    localparam logic [7:0] CMD_READ      = 8'h00;
    localparam logic [7:0] CMD_READ_GO   = 8'h30;
    localparam logic [7:0] CMD_CACHE_GO  = 8'h31;
    localparam logic [7:0] CMD_CACHE_END = 8'h34;
    localparam logic [7:0] CMD_RAND_OUT  = 8'h05;
    localparam logic [7:0] CMD_RAND_GO   = 8'hE0;
    localparam logic [7:0] CMD_PROG_LOAD = 8'h80;
    localparam logic [7:0] CMD_RAND_IN   = 8'h85;
    localparam logic [7:0] CMD_PROG_GO   = 8'h10;
    localparam logic [7:0] CMD_CACHE_PRG = 8'h15;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_RESET     = 8'hFF;

    localparam logic [2:0] PART_MAX   = 3'h4;
    localparam int         PAGE_BYTES = 2112;

    typedef enum logic [2:0] {
        OP_CMD     = 3'h0,
        OP_ADDR4   = 3'h1,
        OP_ADDRCOL = 3'h2,
        OP_WRDATA  = 3'h3,
        OP_RDDATA  = 3'h4
    } npc_op_t;

    typedef struct packed {
        logic ceN;
        logic cle;
        logic ale;
        logic weN;
        logic reN;
        logic wpN;
    } npc_pins_t;

    typedef struct packed {
        logic       isRead;
        logic       cle;
        logic       ale;
        logic [7:0] data;
    } npc_item_t;
endpackage

// *** rtl/npc_bus_cycle.sv ***
// one strobed byte cycle on the flash pins, write or read
`timescale 1ns/100ps
`default_nettype none
module npc_bus_cycle #(
    parameter int DIV = 1
) (
    // system
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    // request
    input  wire logic               start,
    input  wire npc_pkg::npc_item_t item,
    output logic                    busy,
    output logic                    done,
    output logic [7:0]              rdByte,
    // pins
    output logic                    weN,
    output logic                    reN,
    output logic                    cle,
    output logic                    ale,
    output logic [7:0]              dqOut,
    output logic                    dqOe,
    input  wire logic [7:0]         dqIn
);
    import npc_pkg::*;

    npc_item_t   cur;
    logic [1:0]  phase;
    logic [15:0] divCnt;
    wire         tick   = busy && (divCnt == 16'(DIV - 1));
    wire         strobe = busy && (phase == 2'h1 || phase == 2'h2);

    // data latched on the rising write strobe
    assign weN   = !(strobe && !cur.isRead);
    // each falling read strobe yields the next byte
    assign reN   = !(strobe && cur.isRead);
    assign cle   = busy && cur.cle;
    assign ale   = busy && cur.ale;
    assign dqOut = cur.data;
    assign dqOe  = busy && !cur.isRead;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur    <= '0;
            phase  <= 2'h0;
            divCnt <= 16'h0000;
            busy   <= 1'b0;
            done   <= 1'b0;
            rdByte <= 8'h00;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                cur    <= item;
                busy   <= 1'b1;
                phase  <= 2'h0;
                divCnt <= 16'h0000;
            end else if (busy) begin
                divCnt <= tick ? 16'h0000 : divCnt + 16'h0001;
                if (tick) begin
                    // sample late in the low phase, access time covered
                    if (phase == 2'h2 && cur.isRead)
                        rdByte <= dqIn;
                    phase <= phase + 2'h1;
                    if (phase == 2'h3) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/npc_ready_wait.sv ***
// waits for the flash ready line after a busy-making confirm
`timescale 1ns/100ps
`default_nettype none
module npc_ready_wait (
    // system
    input  wire logic clk_sys,
    input  wire logic nrst,
    // control
    input  wire logic start,
    input  wire logic useLimit,
    input  wire logic rbN,
    output logic      busy,
    output logic      done,
    output logic      timedOut
);
    import npc_pkg::*;

    logic [WAIT_W-1:0] cnt;
    logic              limit;
    // the line only drops some time after the confirm edge
    wire guardOver = cnt >= WAIT_W'(TWB_CYC);
    wire expire    = limit && cnt == WAIT_W'(END_CYC);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt      <= '0;
            limit    <= 1'b0;
            busy     <= 1'b0;
            done     <= 1'b0;
            timedOut <= 1'b0;
        end else begin
            done     <= 1'b0;
            timedOut <= 1'b0;
            if (start) begin
                busy  <= 1'b1;
                limit <= useLimit;
                cnt   <= '0;
            end else if (busy) begin
                if (guardOver && rbN) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else if (expire) begin
                    busy     <= 1'b0;
                    timedOut <= 1'b1;
                end else if (cnt != '1) begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/npc_host.sv ***
// wishbone-driven host controller for a multiplexed nand page flash
// Summary of operation
// - command byte latched with CLE on write strobe
// - address byte latched with ALE on write strobe
// - page read is 00h, four addresses, 30h
// - random out 05h/E0h refused in cache read
// - cache read 31h needs column zero
// - after status in cache read, resend 00h
// - 34h or reset idles flash within 5us
// - program is 80h, address, data, 85h, 10h
// - at most four partial programs per page (counted only over consecutive confirms on one row)
// - cache program confirms with 15h
// - next cache sequence only after cache ready
// - ready-line-only users end with 10h
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module npc_host #(
    parameter int STROBE_DIV = 1
) (
    // system
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    // wishbone slave
    input  wire logic [npc_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic [31:0]                    wb_dat_o,
    input  wire logic                      wb_we_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    output logic                           wb_ack_o,
    // flash control pins
    output var npc_pkg::npc_pins_t         pinOut,
    // flash data pins, two-way
    output logic [7:0]                     dqOut,
    output logic                           dqOe,
    input  wire logic [7:0]                dqIn,
    // flash ready line, open drain, high when ready
    input  wire logic                      rbN
);
    import npc_pkg::*;

    typedef enum logic { S_IDLE, S_XFER } npc_state_t;

    npc_state_t  state;
    logic [15:0] colReg;
    logic [15:0] rowReg;
    logic [31:0] cfgReg;
    logic        refused;
    logic        timedOutFlag;
    logic        cacheRead;
    logic        statusMode;
    logic        progPending;
    logic [15:0] progRow;
    logic [2:0]  partCnt;
    logic [7:0]  rdData;

    // latched request
    npc_op_t     opL;
    logic [7:0]  byteL;
    logic [2:0]  lenL;
    logic [2:0]  idx;
    logic        waitL;
    logic        limitL;
    logic        cycStart;

    // engine and wait outputs
    logic        cycBusy;
    logic        cycDone;
    logic [7:0]  cycData;
    logic        cycWeN;
    logic        cycReN;
    logic        cycCle;
    logic        cycAle;
    logic        rwBusy;
    logic        rwDone;
    logic        rwTimeout;
    npc_item_t   item;

    // bus decode
    wire wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wbWr    = wbReq && wb_we_i;
    wire isCmd   = wb_adr_i == REG_CMD;
    wire isAddr  = wb_adr_i == REG_ADDR;
    wire isCfg   = wb_adr_i == REG_CFG;
    wire isStat  = wb_adr_i == REG_STAT;
    wire cmdWr   = wbWr && isCmd && (&wb_sel_i[1:0]);
    wire cfgWp   = cfgReg[CFG_WP_BIT];
    wire cfgPoll = cfgReg[CFG_POLL_BIT];

    wire [31:0] laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] addrWord = {rowReg, colReg};
    wire [31:0] addrNext = (addrWord & ~laneMask) | (wb_dat_i & laneMask);
    wire [31:0] cfgNext  = (cfgReg & ~laneMask) | (wb_dat_i & laneMask);

    // request fields
    wire [7:0] reqByte = wb_dat_i[CMD_BYTE_LSB +: 8];
    wire [2:0] reqOpRaw = wb_dat_i[CMD_OP_LSB +: 3];
    wire       reqLast = wb_dat_i[CMD_LAST_BIT];
    wire       opCmd   = reqOpRaw == OP_CMD;
    wire       opRead  = reqOpRaw == OP_RDDATA;
    wire       badOp   = reqOpRaw > OP_RDDATA;

    wire isConfirm = opCmd &&
                     (reqByte == CMD_PROG_GO || reqByte == CMD_CACHE_PRG);
    wire samePage  = rowReg == progRow;
    // a fifth consecutive program of the same page is never issued
    wire partFull  = isConfirm && samePage && partCnt == PART_MAX;
    // while programming only status and reset may reach the flash
    wire progBlock = progPending && !(opCmd &&
                     (reqByte == CMD_STATUS || reqByte == CMD_RESET));
    wire randBlock = opCmd && reqByte == CMD_RAND_OUT && cacheRead;
    wire colBad    = opCmd && reqByte == CMD_CACHE_GO &&
                     colReg != 16'h0000;
    wire wpBlock   = !cfgWp && (isConfirm ||
                     (opCmd && reqByte == CMD_PROG_LOAD));
    // reading a page before the flash is ready gives stale bytes
    wire rdBlock   = opRead && rwBusy && !statusMode;
    wire refuse    = state != S_IDLE || badOp || partFull || progBlock ||
                     randBlock || colBad || wpBlock || rdBlock;
    wire cmdGo     = cmdWr && !refuse;

    // ready-line-only users must close with a plain program confirm
    wire [7:0] sendByte = (opCmd && reqByte == CMD_CACHE_PRG && reqLast &&
                           !cfgPoll) ? CMD_PROG_GO : reqByte;
    // a read in cache mode after a status poll re-enters with 00h
    wire resume = opRead && cacheRead && statusMode;
    wire [2:0] reqLen = (reqOpRaw == OP_ADDR4)   ? 3'h4 :
                        (reqOpRaw == OP_ADDRCOL) ? 3'h2 :
                        resume                   ? 3'h2 : 3'h1;
    wire goBusy = opCmd && (sendByte == CMD_READ_GO ||
                  sendByte == CMD_CACHE_GO || sendByte == CMD_PROG_GO ||
                  sendByte == CMD_CACHE_PRG || sendByte == CMD_CACHE_END ||
                  sendByte == CMD_RESET);
    wire goLimit = opCmd && (sendByte == CMD_CACHE_END ||
                   sendByte == CMD_RESET);

    // current byte of the latched sequence
    wire       lastItem   = idx == lenL - 3'h1;
    wire       itemIsRead = opL == OP_RDDATA && lastItem;
    wire       itemIsCmd  = opL == OP_CMD ||
                            (opL == OP_RDDATA && !lastItem);
    wire       itemIsAddr = opL == OP_ADDR4 || opL == OP_ADDRCOL;
    // column low, column high, row low, row high
    wire [7:0] addrByte   = addrWord[{idx[1:0], 3'b000} +: 8];
    wire [7:0] itemData   = itemIsAddr ? addrByte :
                            (opL == OP_RDDATA) ? CMD_READ : byteL;

    assign item = '{isRead: itemIsRead, cle: itemIsCmd,
                    ale: itemIsAddr, data: itemData};

    wire [31:0] statWord = {13'h0000, partCnt, rdData, rwBusy, statusMode,
                            progPending, cacheRead, timedOutFlag, refused,
                            rbN, state != S_IDLE};
    wire [31:0] rdMux = isCmd  ? 32'h0000_0000 :
                        isAddr ? addrWord :
                        isCfg  ? cfgReg :
                        isStat ? statWord : 32'h0000_0000;

    // pins; chip enable drops only around byte cycles so the flash
    // may idle in standby, and busy work is not disturbed by it
    assign pinOut = '{ceN: state == S_IDLE, cle: cycCle, ale: cycAle,
                      weN: cycWeN, reN: cycReN, wpN: cfgWp};

    // wishbone slave: one wait state, unmapped reads give zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wbReq;
            wb_dat_o <= (wbReq && !wb_we_i) ? rdMux : 32'h0000_0000;
        end
    end

    // software registers and sticky flags
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            colReg       <= 16'h0000;
            rowReg       <= 16'h0000;
            cfgReg       <= CFG_RESET;
            refused      <= 1'b0;
            timedOutFlag <= 1'b0;
        end else begin
            if (wbWr && isAddr) begin
                colReg <= addrNext[15:0];
                rowReg <= addrNext[31:16];
            end
            if (wbWr && isCfg)
                cfgReg <= cfgNext;
            // set wins over a write-one clear in the same cycle
            if (cmdWr && refuse)
                refused <= 1'b1;
            else if (wbWr && isStat && wb_sel_i[0] && wb_dat_i[ST_REF_BIT])
                refused <= 1'b0;
            if (rwTimeout)
                timedOutFlag <= 1'b1;
            else if (wbWr && isStat && wb_sel_i[0] && wb_dat_i[ST_TMO_BIT])
                timedOutFlag <= 1'b0;
        end
    end

    // flash mode tracking; power-up read mode needs no 00h
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cacheRead   <= 1'b0;
            statusMode  <= 1'b0;
            progPending <= 1'b0;
            progRow     <= 16'h0000;
            partCnt     <= 3'h0;
        end else begin
            if (cmdGo && opCmd) begin
                statusMode <= sendByte == CMD_STATUS;
                if (sendByte == CMD_CACHE_GO)
                    cacheRead <= 1'b1;
                else if (sendByte == CMD_CACHE_END || sendByte == CMD_RESET)
                    cacheRead <= 1'b0;
            end else if (cmdGo && resume) begin
                statusMode <= 1'b0;
            end
            // new confirm wins over the end of the previous wait
            if (cmdGo && isConfirm)
                progPending <= 1'b1;
            else if (cmdGo && opCmd && sendByte == CMD_RESET)
                progPending <= 1'b0;
            else if (rwDone || rwTimeout)
                progPending <= 1'b0;
            if (cmdGo && isConfirm) begin
                progRow <= rowReg;
                partCnt <= samePage ? partCnt + 3'h1 : 3'h1;
            end
        end
    end

    // sequence engine
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state    <= S_IDLE;
            opL      <= OP_CMD;
            byteL    <= 8'h00;
            lenL     <= 3'h1;
            idx      <= 3'h0;
            waitL    <= 1'b0;
            limitL   <= 1'b0;
            cycStart <= 1'b0;
            rdData   <= 8'h00;
        end else begin
            cycStart <= 1'b0;
            if (cycDone && itemIsRead)
                rdData <= cycData;
            unique case (state)
                S_IDLE: begin
                    if (cmdGo) begin
                        opL      <= npc_op_t'(reqOpRaw);
                        byteL    <= sendByte;
                        lenL     <= reqLen;
                        idx      <= 3'h0;
                        waitL    <= goBusy;
                        limitL   <= goLimit;
                        cycStart <= 1'b1;
                        state    <= S_XFER;
                    end
                end
                S_XFER: begin
                    if (cycDone) begin
                        if (lastItem) begin
                            state <= S_IDLE;
                        end else begin
                            idx      <= idx + 3'h1;
                            cycStart <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    wire rwStart = cycDone && state == S_XFER && lastItem && waitL;

    npc_bus_cycle #(
        .DIV    (STROBE_DIV)
    ) u_cycle (
        .clk_sys(clk_sys),
        .nrst   (nrst),
        .start  (cycStart),
        .item   (item),
        .busy   (cycBusy),
        .done   (cycDone),
        .rdByte (cycData),
        .weN    (cycWeN),
        .reN    (cycReN),
        .cle    (cycCle),
        .ale    (cycAle),
        .dqOut  (dqOut),
        .dqOe   (dqOe),
        .dqIn   (dqIn)
    );

    npc_ready_wait u_wait (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .start   (rwStart),
        .useLimit(limitL),
        .rbN     (rbN),
        .busy    (rwBusy),
        .done    (rwDone),
        .timedOut(rwTimeout)
    );
endmodule
`default_nettype wire

// *** testbench/npc_flash_model.sv ***
// behavioural nand flash facing the host controller pins
`timescale 1ns/100ps
`default_nettype none
module npc_flash_model #(
    parameter int BUSY = 20
) (
    // system
    input wire logic               clk_sys,
    // pins from the host
    input wire npc_pkg::npc_pins_t pinOut,
    input wire logic [7:0]         dqOut,
    // answers
    output logic [7:0]             dqIn,
    output logic                   rbN
);
    import npc_pkg::*;
    logic [7:0] mem [int];
    int         pcnt [int];
    int         col, row, acnt, bsy, ncmd;
    logic [7:0] lastCmd;
    logic       stMode, fail;
    initial begin
        {col, row, acnt, bsy, ncmd} = '0;
        {lastCmd, stMode, fail, dqIn} = '0;
        rbN = 1'b1;
    end
    always @(posedge pinOut.weN) begin
        if (!pinOut.ceN && pinOut.cle) begin
            ncmd++;
            lastCmd = dqOut;
            acnt = 0;
            stMode = dqOut == CMD_STATUS;
            if (dqOut inside {8'h30, 8'h31, 8'h10, 8'h15, 8'h34, 8'hFF})
                bsy = BUSY;
            if (dqOut inside {8'h10, 8'h15})
                pcnt[row]++;
            if (pcnt[row] > 4)
                fail = 1'b1;
            if (dqOut == CMD_RESET)
                fail = 1'b0;
        end else if (!pinOut.ceN && pinOut.ale) begin
            case (acnt)
                0: col = dqOut;
                1: col |= int'(dqOut[3:0]) << 8;
                2: row = dqOut;
                default: row |= int'(dqOut) << 8;
            endcase
            acnt++;
        end else if (!pinOut.ceN && pinOut.wpN) begin
            mem[row * 4096 + col] = dqOut;
            col++;
        end
    end
    // a released bus must not keep showing the last byte
    always @(posedge pinOut.reN) dqIn <= ~dqIn;
    always @(negedge pinOut.reN) begin
        if (stMode)
            dqIn <= {pinOut.wpN, rbN, rbN, 3'h0, fail, fail};
        else begin
            dqIn <= mem.exists(row * 4096 + col) ?
                    mem[row * 4096 + col] : 8'hFF;
            col++;
        end
    end
    // counts on the clock only, so chip enable cannot cut it short
    always @(posedge clk_sys) begin
        if (bsy > 0)
            bsy--;
        rbN <= bsy == 0;
    end
endmodule
`default_nettype wire

// *** testbench/npc_host_checker.sv ***
// port assertions of the nand host controller
`timescale 1ns/100ps
`default_nettype none
module npc_host_checker #(
    parameter int STROBE_DIV = 1
) (
    // system
    input wire logic                      clk_sys,
    input wire logic                      nrst,
    // wishbone
    input wire logic [npc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0]               wb_dat_i,
    input wire logic                      wb_we_i,
    input wire logic [3:0]                wb_sel_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_ack_o,
    // flash pins
    input wire npc_pkg::npc_pins_t        pinOut,
    input wire logic [7:0]                dqOut,
    input wire logic                      dqOe
);
    import npc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire cfgWr = wb_ack_o && wb_we_i && wb_adr_i == REG_CFG && wb_sel_i[0];
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_wp_cfg: assert property (cfgWr |=> pinOut.wpN == $past(wb_dat_i[0]))
        else $error("write protect pin does not follow config");
    a_latch_excl: assert property (!(pinOut.cle && pinOut.ale))
        else $error("command and address latch both high");
    a_strobe_ce: assert property (!pinOut.weN || !pinOut.reN |-> !pinOut.ceN)
        else $error("strobe while chip not enabled");
    a_wr_drive: assert property (!pinOut.weN |-> dqOe && $stable(dqOut)
        && $stable(pinOut.cle) && $stable(pinOut.ale))
        else $error("byte or latch changed during write strobe");
    a_rd_float: assert property (!pinOut.reN |-> !dqOe && !pinOut.cle)
        else $error("host drives bus during read strobe");
    a_wr_width: assert property (STROBE_DIV == 1 && $fell(pinOut.weN)
        |=> !pinOut.weN ##1 pinOut.weN)
        else $error("write strobe width wrong");
    c_read: cover property ($fell(pinOut.reN));
    c_addr: cover property (!pinOut.weN && pinOut.ale);
    c_cfg: cover property (cfgWr);
endmodule
bind npc_host npc_host_checker #(.STROBE_DIV(STROBE_DIV)) u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .pinOut(pinOut), .dqOut(dqOut), .dqOe(dqOe));
`default_nettype wire

// *** testbench/npc_host_tb.sv ***
// self-checking bench of the nand host controller
`timescale 1ns/100ps
`default_nettype none
module npc_host_tb;
    import npc_pkg::*;
    logic        clk_sys, nrst, we, cyc, stb, ack, dqOe, rbN;
    logic [7:0]  adr, dqOut, dqIn, b;
    logic [31:0] dat, datO, st;
    logic [3:0]  sel;
    npc_pins_t   pins;
    int          miscompares, n_tests, seed, nc, i;
    logic [7:0]  shadow [int];
    npc_host #(.STROBE_DIV(1)) dut (.clk_sys(clk_sys), .nrst(nrst),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(datO), .wb_we_i(we),
        .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .pinOut(pins), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .rbN(rbN));
    npc_flash_model fm (.clk_sys(clk_sys), .pinOut(pins), .dqOut(dqOut),
        .dqIn(dqIn), .rbN(rbN));
    task automatic end_sim;
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // held until the edge that samples ack, read data taken there
    task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge clk_sys);
        adr <= a;
        dat <= d;
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        do @(posedge clk_sys); while (ack !== 1'b1);
        st = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic op(input logic [2:0] o, input logic [7:0] c,
                      input logic l = 1'b0);
        wb(REG_CMD, {20'h0, l, o, c}, 1'b1);
        do wb(REG_STAT, 32'h0, 1'b0);
        while (st[ST_ENG_BIT] !== 1'b0 || st[ST_WAIT_BIT] !== 1'b0);
    endtask
    task automatic refchk(input logic e);
        wb(REG_STAT, 32'h0, 1'b0);
        chk("refused", e, st[ST_REF_BIT]);
        wb(REG_STAT, 32'h0000000C, 1'b1);
    endtask
    task automatic seq(input logic [7:0] c, input logic [15:0] cl, r,
                       input logic [2:0] ao = 3'h1);
        wb(REG_ADDR, {r, cl}, 1'b1);
        op(3'h0, c);
        op(ao, 8'h00);
    endtask
    task automatic rdb(input logic [7:0] e);
        op(3'h4, 8'h00);
        chk("read byte", e, st[ST_DATA_LSB+:8]);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #(30000 * 100);
        miscompares++;
        end_sim;
    end
    initial begin
        {nrst, we, cyc, stb, adr, dat} = '0;
        sel = 4'hF;
        seed = $urandom(32'h6dfa80d5);
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        chk("pins", 32'h26, pins);
        wb(REG_CFG, 32'h0, 1'b0);
        chk("cfg", CFG_RESET, st);
        wb(8'h10, 32'h0, 1'b0);
        chk("unmapped", 32'h0, st);
        nc = fm.ncmd;
        op(3'h0, CMD_PROG_LOAD);
        refchk(1'b1);
        chk("flash cmds", nc, fm.ncmd);
        wb(REG_CFG, 32'h1, 1'b1);
        seq(CMD_PROG_LOAD, 16'h0, 16'h3);
        chk("wp pin", 1'b1, pins.wpN);
        for (i = 0; i < 6; i++) begin
            shadow[i] = 8'($urandom);
            op(3'h3, shadow[i]);
        end
        seq(CMD_RAND_IN, 16'h64, 16'h3, 3'h2);
        shadow[100] = 8'($urandom);
        op(3'h3, shadow[100]);
        op(3'h0, CMD_PROG_GO, 1'b1);
        op(3'h0, CMD_STATUS);
        rdb(8'hE0);
        seq(CMD_READ, 16'h0, 16'h3);
        op(3'h0, CMD_READ_GO);
        for (i = 0; i < 6; i++)
            rdb(shadow[i]);
        seq(CMD_RAND_OUT, 16'h64, 16'h3, 3'h2);
        op(3'h0, CMD_RAND_GO);
        rdb(shadow[100]);
        seq(CMD_READ, 16'h5, 16'h3);
        op(3'h0, CMD_CACHE_GO);
        refchk(1'b1);
        seq(CMD_READ, 16'h0, 16'h3);
        op(3'h0, CMD_CACHE_GO);
        chk("cache on", 1'b1, st[ST_CRD_BIT]);
        op(3'h0, CMD_RAND_OUT);
        refchk(1'b1);
        // a read after a status poll in cache mode re-enters with 00h
        op(3'h0, CMD_STATUS);
        rdb(shadow[0]);
        chk("resume", CMD_READ, fm.lastCmd);
        op(3'h0, CMD_CACHE_END);
        chk("cache end", 2'b00, {st[ST_CRD_BIT], st[ST_TMO_BIT]});
        // fifth confirm on one row must never reach the flash
        for (i = 0; i < 5; i++) begin
            seq(CMD_PROG_LOAD, 16'h0, 16'h7);
            op(3'h3, 8'($urandom));
            op(3'h0, CMD_CACHE_PRG, 1'b1);
            chk("confirm", i == 4 ? CMD_PROG_LOAD : CMD_PROG_GO, fm.lastCmd);
            refchk(i == 4);
        end
        // poll mode keeps the cache confirm on the last page
        wb(REG_CFG, 32'h3, 1'b1);
        seq(CMD_PROG_LOAD, 16'h0, 16'h9);
        op(3'h3, 8'($urandom));
        op(3'h0, CMD_CACHE_PRG, 1'b1);
        chk("poll confirm", CMD_CACHE_PRG, fm.lastCmd);
        op(3'h0, CMD_RESET);
        op(3'h0, CMD_STATUS);
        rdb(8'hE0);
        end_sim;
    end
endmodule
`default_nettype wire
